// >>> logic/rocb_defs.svh
// register offsets, reset values, limits and field positions of the bank
// assumes command codes arrive already framed by the bus transaction layer
`ifndef ROCB_DEFS_SVH
`define ROCB_DEFS_SVH

`define ROCB_CMD_TRIM      8'h22
`define ROCB_CMD_VMAX      8'h24
`define ROCB_CMD_MHIGH     8'h25
`define ROCB_CMD_MLOW      8'h26
`define ROCB_CMD_SLEW      8'h27
`define ROCB_CMD_SCALE     8'h29
`define ROCB_CMD_FSW       8'h33
`define ROCB_CMD_INPUT_TURN_ON_LEVEL    8'h35
`define ROCB_CMD_INPUT_TURN_OFF_LEVEL   8'h36
`define ROCB_CMD_PHASE     8'h37
`define ROCB_CMD_OVF       8'h40
`define ROCB_CMD_OVACT     8'h41
`define ROCB_CMD_OVW       8'h42
`define ROCB_CMD_UVW       8'h43

`define ROCB_RST_TRIM      16'h0000
`define ROCB_RST_VMAX      16'h1c00
`define ROCB_RST_MHIGH     16'h0142
`define ROCB_RST_MLOW      16'h0123
`define ROCB_RST_SLEW      16'he002
`define ROCB_RST_SCALE     16'he808
`define ROCB_RST_FSW       16'h0258
`define ROCB_RST_INPUT_TURN_ON_LEVEL    16'hf814
`define ROCB_RST_INPUT_TURN_OFF_LEVEL   16'h0100
`define ROCB_RST_PHASE     16'h0100
`define ROCB_RST_OVF       16'h0161
`define ROCB_RST_OVACT     8'hf8
`define ROCB_RST_OVW       16'h0151
`define ROCB_RST_UVW       16'h0114

// output voltage words: exponent -9, 1 lsb = 1.953 mV
`define ROCB_VOUT_EXP      (-9)
`define ROCB_V_MIN         16'h009a
`define ROCB_V_MAX         16'h1c00
`define ROCB_V_ZERO        16'h0000
`define ROCB_TRIM_LIM      16'h0400

// phase role word fields
`define ROCB_ROLE_HI       11
`define ROCB_ROLE_LO       8
`define ROCB_POS_HI        7
`define ROCB_POS_LO        4
`define ROCB_PHASE_MASK    16'h0ff0

// fault action field positions
`define ROCB_ACT_HI        7
`define ROCB_ACT_LO        6

`endif

// >>> logic/rocb_pkg.sv
// types shared by the configuration bank and its restart controller
// assumes rocb_defs.svh sits on the include path
package rocb_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } rocb_req_t;

  typedef struct packed {
    logic        ack;
    logic        nack;
    logic [15:0] rdata;
  } rocb_resp_t;

  typedef struct packed {
    logic [15:0] trim;
    logic [15:0] vmax;
    logic [15:0] mhigh;
    logic [15:0] mlow;
    logic [15:0] slew;
    logic [15:0] scale;
    logic [15:0] fsw;
    logic [15:0] input_turn_on_level;
    logic [15:0] input_turn_off_level;
    logic [15:0] phase;
    logic [15:0] ovf;
    logic [7:0]  ovact;
    logic [15:0] ovw;
    logic [15:0] uvw;
  } rocb_cfg_t;

  typedef enum logic [2:0] {
    ROCB_ST_RUN   = 3'b001,
    ROCB_ST_HOLD  = 3'b010,
    ROCB_ST_LATCH = 3'b100
  } rocb_ov_state_t;

endpackage

// >>> logic/rocb_ov_restart.sv
// output overvoltage response: gates the output enable from the fault
// assumes fault and command inputs are already on clk_in
`timescale 1ns/1ps
`include "rocb_defs.svh"
module rocb_ov_restart (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // conditions
  input  wire logic       ov_fault_in,
  input  wire logic       cmd_on_in,
  input  wire logic       bias_ok_in,
  input  wire logic       other_fault_in,
  input  wire logic [7:0] action_in,
  // result
  output logic            out_enable_out,
  output logic            restart_wait_out
);
  import rocb_pkg::*;

  rocb_ov_state_t state_reg;
  rocb_ov_state_t state_next;
  logic           off_cond;
  logic [1:0]     act;

  assign off_cond = !cmd_on_in || !bias_ok_in || other_fault_in;
  assign act      = action_in[`ROCB_ACT_HI:`ROCB_ACT_LO];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ROCB_ST_RUN: begin
        if (ov_fault_in && !off_cond && act != 2'b00) begin
          // disable while fault persists, else latch off
          if (act == 2'b11) state_next = ROCB_ST_HOLD;
          else state_next = ROCB_ST_LATCH;
        end
      end
      ROCB_ST_HOLD: begin
        // retries never run out; an off condition or the fault clearing ends them
        if (off_cond) state_next = ROCB_ST_RUN;
        else if (!ov_fault_in) state_next = ROCB_ST_RUN;
      end
      ROCB_ST_LATCH: begin
        if (off_cond) state_next = ROCB_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg        <= ROCB_ST_RUN;
      out_enable_out   <= 1'b0;
      restart_wait_out <= 1'b0;
    end else begin
      state_reg        <= state_next;
      out_enable_out   <= !off_cond && (state_next == ROCB_ST_RUN);
      restart_wait_out <= (state_next == ROCB_ST_HOLD);
    end
  end

endmodule

// >>> logic/rocb_bank.sv
// output configuration register bank reached by command code
// assumes a same-clock bus transaction layer issuing one-cycle strobes;
// fault and enable pins come from outside and are synchronised here
`timescale 1ns/1ps
`include "rocb_defs.svh"
module rocb_bank (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // command port from the bus transaction layer
  input  rocb_pkg::rocb_req_t    req_in,
  output rocb_pkg::rocb_resp_t   resp_out,
  output logic                   bad_data_out,
  // factory trim from non-volatile store
  input  wire logic [15:0]       factory_trim_in,
  // pins
  input  wire logic              ov_fault_in,
  input  wire logic              cmd_on_in,
  input  wire logic              bias_ok_in,
  input  wire logic              other_fault_in,
  // regulator side
  output rocb_pkg::rocb_cfg_t    cfg_out,
  output logic                   out_enable_out,
  output logic                   restart_wait_out,
  output logic                   phase_master_out,
  output logic [3:0]             phase_pos_out
);
  import rocb_pkg::*;

  rocb_cfg_t   cfg_reg;
  rocb_resp_t  resp_reg;
  logic        bad_reg;
  logic        loaded_reg;
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic        hit;
  logic        ok;
  logic [15:0] rd_word;
  logic [15:0] d;

  assign d = req_in.data;

  // output voltage range check, unsigned mantissa with exponent -9
  function automatic logic v_in_range(input logic [15:0] w,
                                      input logic [15:0] lo);
    v_in_range = (w >= lo) && (w <= `ROCB_V_MAX);
  endfunction

  // short-float power of two between 2^-3 and 2^0
  function automatic logic scale_ok(input logic [15:0] w);
    int e;
    int p;
    logic found;
    e = int'($signed(w[15:11]));
    p = 0;
    found = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (w[10:0] == (11'h001 << i)) begin
        p = e + i;
        found = 1'b1;
      end
    end
    scale_ok = found && (p >= -3) && (p <= 0);
  endfunction

  function automatic logic act_ok(input logic [7:0] a);
    unique case (a)
      8'h00, 8'h16, 8'h22, 8'h36, 8'hc0,
      8'hd6, 8'he2, 8'hf6, 8'hf8: act_ok = 1'b1;
      default: act_ok = 1'b0;
    endcase
  endfunction

  // decode and value check
  always_comb begin
    hit     = 1'b1;
    ok      = 1'b1;
    rd_word = 16'h0000;
    unique case (req_in.code)
      `ROCB_CMD_TRIM: begin
        rd_word = cfg_reg.trim;
        ok = ($signed(d) >= -$signed(`ROCB_TRIM_LIM)) &&
             ($signed(d) <= $signed(`ROCB_TRIM_LIM));
      end
      `ROCB_CMD_VMAX: begin
        rd_word = cfg_reg.vmax;
        ok = v_in_range(d, `ROCB_V_MIN);
      end
      `ROCB_CMD_MHIGH: begin
        rd_word = cfg_reg.mhigh;
        ok = v_in_range(d, `ROCB_V_MIN);
      end
      `ROCB_CMD_MLOW: begin
        rd_word = cfg_reg.mlow;
        ok = v_in_range(d, `ROCB_V_MIN);
      end
      `ROCB_CMD_SLEW:    rd_word = cfg_reg.slew;
      `ROCB_CMD_SCALE: begin
        rd_word = cfg_reg.scale;
        ok = scale_ok(d);
      end
      `ROCB_CMD_FSW:     rd_word = cfg_reg.fsw;
      `ROCB_CMD_INPUT_TURN_ON_LEVEL:  rd_word = cfg_reg.input_turn_on_level;
      `ROCB_CMD_INPUT_TURN_OFF_LEVEL: rd_word = cfg_reg.input_turn_off_level;
      `ROCB_CMD_PHASE:   rd_word = cfg_reg.phase & `ROCB_PHASE_MASK;
      `ROCB_CMD_OVF: begin
        rd_word = cfg_reg.ovf;
        ok = v_in_range(d, `ROCB_V_MIN);
      end
      `ROCB_CMD_OVACT: begin
        rd_word = {8'h00, cfg_reg.ovact};
        ok = act_ok(d[7:0]) && (d[15:8] == 8'h00);
      end
      `ROCB_CMD_OVW: begin
        rd_word = cfg_reg.ovw;
        ok = v_in_range(d, `ROCB_V_MIN);
      end
      `ROCB_CMD_UVW: begin
        rd_word = cfg_reg.uvw;
        ok = v_in_range(d, `ROCB_V_ZERO);
      end
      default: begin
        hit = 1'b0;
        ok  = 1'b0;
      end
    endcase
  end

  // register writes; factory trim taken once after reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg.trim    <= `ROCB_RST_TRIM;
      cfg_reg.vmax    <= `ROCB_RST_VMAX;
      cfg_reg.mhigh   <= `ROCB_RST_MHIGH;
      cfg_reg.mlow    <= `ROCB_RST_MLOW;
      cfg_reg.slew    <= `ROCB_RST_SLEW;
      cfg_reg.scale   <= `ROCB_RST_SCALE;
      cfg_reg.fsw     <= `ROCB_RST_FSW;
      cfg_reg.input_turn_on_level  <= `ROCB_RST_INPUT_TURN_ON_LEVEL;
      cfg_reg.input_turn_off_level <= `ROCB_RST_INPUT_TURN_OFF_LEVEL;
      cfg_reg.phase   <= `ROCB_RST_PHASE;
      cfg_reg.ovf     <= `ROCB_RST_OVF;
      cfg_reg.ovact   <= `ROCB_RST_OVACT;
      cfg_reg.ovw     <= `ROCB_RST_OVW;
      cfg_reg.uvw     <= `ROCB_RST_UVW;
      loaded_reg      <= 1'b0;
    end else if (!loaded_reg) begin
      cfg_reg.trim <= factory_trim_in;
      loaded_reg   <= 1'b1;
    end else if (req_in.wr && ok) begin
      unique case (req_in.code)
        `ROCB_CMD_TRIM:    cfg_reg.trim    <= d;
        `ROCB_CMD_VMAX:    cfg_reg.vmax    <= d;
        `ROCB_CMD_MHIGH:   cfg_reg.mhigh   <= d;
        `ROCB_CMD_MLOW:    cfg_reg.mlow    <= d;
        `ROCB_CMD_SLEW:    cfg_reg.slew    <= d;
        `ROCB_CMD_SCALE:   cfg_reg.scale   <= d;
        `ROCB_CMD_FSW:     cfg_reg.fsw     <= d;
        `ROCB_CMD_INPUT_TURN_ON_LEVEL:  cfg_reg.input_turn_on_level  <= d;
        `ROCB_CMD_INPUT_TURN_OFF_LEVEL: cfg_reg.input_turn_off_level <= d;
        `ROCB_CMD_PHASE:   cfg_reg.phase   <= d & `ROCB_PHASE_MASK;
        `ROCB_CMD_OVF:     cfg_reg.ovf     <= d;
        `ROCB_CMD_OVACT:   cfg_reg.ovact   <= d[7:0];
        `ROCB_CMD_OVW:     cfg_reg.ovw     <= d;
        `ROCB_CMD_UVW:     cfg_reg.uvw     <= d;
        default: ;
      endcase
    end
  end

  // answer one cycle after each strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_reg <= '0;
      bad_reg  <= 1'b0;
    end else begin
      resp_reg.ack   <= (req_in.rd && hit) || (req_in.wr && ok && loaded_reg);
      resp_reg.nack  <= (req_in.rd && !hit) ||
                        (req_in.wr && !(ok && loaded_reg));
      resp_reg.rdata <= (req_in.rd && hit) ? rd_word : 16'h0000;
      bad_reg        <= req_in.wr && hit && !ok;
    end
  end

  // pin synchronisers: ov fault, command on, bias ok, other fault
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {other_fault_in, bias_ok_in, cmd_on_in, ov_fault_in};
      sync2_reg <= sync1_reg;
    end
  end

  // phase role outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_master_out <= 1'b1;
      phase_pos_out    <= 4'h0;
    end else begin
      phase_master_out <= (cfg_reg.phase[`ROCB_POS_HI:`ROCB_POS_LO]
                           == 4'h0);
      phase_pos_out    <= cfg_reg.phase[`ROCB_POS_HI:`ROCB_POS_LO];
    end
  end

  rocb_ov_restart u_ov (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .ov_fault_in      (sync2_reg[0]),
    .cmd_on_in        (sync2_reg[1]),
    .bias_ok_in       (sync2_reg[2]),
    .other_fault_in   (sync2_reg[3]),
    .action_in        (cfg_reg.ovact),
    .out_enable_out   (out_enable_out),
    .restart_wait_out (restart_wait_out)
  );

  assign cfg_out      = cfg_reg;
  assign resp_out     = resp_reg;
  assign bad_data_out = bad_reg;

endmodule

// >>> tb/rocb_bank_assertions.sv
// concurrent checks on the configuration bank ports
// assumes binding onto every rocb_bank instance, one clock domain
`timescale 1ns/1ps
module rocb_bank_chk (
  // clock and reset
  input wire logic            clk_in,
  input wire logic            rst_n_in,
  // command port
  input rocb_pkg::rocb_req_t  req_in,
  input rocb_pkg::rocb_resp_t resp_out,
  input wire logic            bad_data_out,
  // pins and results
  input wire logic            ov_fault_in,
  input wire logic            cmd_on_in,
  input wire logic            bias_ok_in,
  input wire logic            other_fault_in,
  input rocb_pkg::rocb_cfg_t  cfg_out,
  input wire logic            out_enable_out,
  input wire logic            restart_wait_out,
  input wire logic            phase_master_out,
  input wire logic [3:0]      phase_pos_out
);
  import rocb_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wr(c);
    req_in.wr && req_in.code == c && $past(rst_n_in);
  endsequence
  sequence s_f8(f);
    (cmd_on_in && bias_ok_in && !other_fault_in && ov_fault_in == f
     && cfg_out.ovact == 8'hf8) [*5];
  endsequence
  property p_trim_rng;
    s_wr(8'h22) ##0 ($signed(req_in.data) > 16'sh0400 || $signed(req_in.data)
      < -16'sh0400) |-> ##1 resp_out.nack && bad_data_out;
  endproperty
  a_trim_rng: assert property (p_trim_rng)
    else $error("trim outside two volts was taken");
  property p_trim_ok;
    s_wr(8'h22) ##0 ($signed(req_in.data) <= 16'sh0400 && $signed(req_in.data)
      >= -16'sh0400) |-> ##1 resp_out.ack && cfg_out.trim == $past(req_in.data);
  endproperty
  a_trim_ok: assert property (p_trim_ok)
    else $error("legal trim not stored");
  property p_scale_bad;
    s_wr(8'h29) ##0 req_in.data[10:0] == 11'h000
      |-> ##1 resp_out.nack && $stable(cfg_out.scale);
  endproperty
  a_scale_bad: assert property (p_scale_bad)
    else $error("zero loop scale was taken");
  property p_scale_rd;
    req_in.rd && req_in.code == 8'h29 && $past(rst_n_in)
      |-> ##1 resp_out.ack && resp_out.rdata == cfg_out.scale;
  endproperty
  a_scale_rd: assert property (p_scale_rd)
    else $error("loop scale read differs from stored word");
  property p_ov_hold;
    out_enable_out ##0 s_f8(1'b1) |-> !out_enable_out && restart_wait_out;
  endproperty
  a_ov_hold: assert property (p_ov_hold)
    else $error("output stays on during overvoltage");
  property p_ov_resume;
    restart_wait_out ##0 s_f8(1'b0) |-> out_enable_out && !restart_wait_out;
  endproperty
  a_ov_resume: assert property (p_ov_resume)
    else $error("output not back after overvoltage cleared");
  property p_off_end;
    (!cmd_on_in) [*5] |-> !out_enable_out && !restart_wait_out;
  endproperty
  a_off_end: assert property (p_off_end)
    else $error("output or retry alive while commanded off");
  property p_phase_wr;
    s_wr(8'h37) |-> ##1 cfg_out.phase == ($past(req_in.data) & 16'h0ff0);
  endproperty
  a_phase_wr: assert property (p_phase_wr)
    else $error("phase word unused bits not cleared");
  property p_phase_pin;
    $stable(cfg_out.phase) |-> phase_pos_out == cfg_out.phase[7:4]
      && phase_master_out == (cfg_out.phase[7:4] == 4'h0);
  endproperty
  a_phase_pin: assert property (p_phase_pin)
    else $error("phase position outputs disagree with word");
  property p_vout_rng;
    s_wr(8'h24) ##0 (req_in.data > 16'h1c00 || req_in.data < 16'h009a)
      |-> ##1 resp_out.nack && bad_data_out && $stable(cfg_out.vmax);
  endproperty
  a_vout_rng: assert property (p_vout_rng)
    else $error("ceiling outside range was taken");
endmodule

bind rocb_bank rocb_bank_chk rocb_bank_chk_inst (.clk_in, .rst_n_in,
  .req_in, .resp_out, .bad_data_out, .ov_fault_in, .cmd_on_in, .bias_ok_in,
  .other_fault_in, .cfg_out, .out_enable_out, .restart_wait_out,
  .phase_master_out, .phase_pos_out);

// >>> tb/rocb_host.sv
// host model issuing one-cycle command strobes to the bank
// assumes the answer arrives one cycle after the strobe edge
`timescale 1ns/1ps
module rocb_host (
  // clock
  input  wire logic            clk_in,
  // command port
  output rocb_pkg::rocb_req_t  req_out,
  input  rocb_pkg::rocb_resp_t resp_in
);
  import rocb_pkg::*;
  initial req_out = '0;
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, output rocb_resp_t rsp);
    @(posedge clk_in);
    #2;
    req_out = {wr, !wr, code, data};
    @(posedge clk_in);
    #2;
    // released lines show the inverse so stale data cannot pass
    req_out = {2'b00, ~code, ~data};
    @(posedge clk_in);
    rsp = resp_in;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the configuration bank with a host model
// assumes the checker is bound through its own file
`timescale 1ns/1ps
module tb;
  import rocb_pkg::*;
  logic        clk_in, rst_n_in, ov_fault_in, cmd_on_in, bias_ok_in;
  logic        other_fault_in, bad_data_out, out_enable_out;
  logic        restart_wait_out, phase_master_out;
  logic [3:0]  phase_pos_out;
  logic [15:0] factory_trim_in;
  rocb_req_t   req_in;
  rocb_resp_t  resp_out, rsp;
  rocb_cfg_t   cfg_out;
  int          fail_count, compares;
  logic [15:0] mdl[int];
  logic [7:0]  fr[4] = '{8'h27, 8'h33, 8'h35, 8'h36};
  logic [15:0] ptab[3] = '{16'hffff, 16'h0000, 16'h0130};
  logic [23:0] wtab[$] = '{24'h22_0400, 24'h22_fc00, 24'h22_0401,
    24'h22_fbff, 24'h24_009a, 24'h24_0099, 24'h24_1c00, 24'h24_1c01,
    24'h25_0200, 24'h25_0099, 24'h26_0150, 24'h26_1c01, 24'h42_0151,
    24'h42_0000, 24'h40_1c01,
    24'h43_0000, 24'h43_1c01, 24'h40_0161, 24'h29_e801, 24'h29_f001,
    24'h29_e002, 24'h29_e804, 24'h29_0001, 24'h29_0002, 24'h29_e001,
    24'h29_e803, 24'h29_e800, 24'h29_eff8, 24'h29_e808, 24'h41_0000,
    24'h41_0016, 24'h41_0022, 24'h41_0036, 24'h41_00c0, 24'h41_00d6,
    24'h41_00e2, 24'h41_00f6, 24'h41_0017, 24'h41_01f8, 24'h41_00f8};
  rocb_bank rocb_bank_inst (.clk_in, .rst_n_in, .req_in, .resp_out,
    .bad_data_out, .factory_trim_in, .ov_fault_in, .cmd_on_in, .bias_ok_in,
    .other_fault_in, .cfg_out, .out_enable_out, .restart_wait_out,
    .phase_master_out, .phase_pos_out);
  rocb_host rocb_host_inst (.clk_in, .req_out(req_in), .resp_in(resp_out));
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic bit legal(logic [7:0] c, logic [15:0] d);
    int m, e, k;
    case (c)
      8'h22: return $signed(d) <= 16'sh0400 && $signed(d) >= -16'sh0400;
      8'h24, 8'h25, 8'h26, 8'h40, 8'h42: return d >= 16'h009a && d <= 16'h1c00;
      8'h43: return d <= 16'h1c00;
      8'h41: return d inside {16'h0000, 16'h0016, 16'h0022, 16'h0036,
        16'h00c0, 16'h00d6, 16'h00e2, 16'h00f6, 16'h00f8};
      8'h29: begin
        m = $signed(d[10:0]);
        e = $signed(d[15:11]);
        k = 0;
        if (m <= 0 || (m & (m - 1)) != 0) return 0;
        while (m > 1) begin
          m = m >> 1;
          k++;
        end
        return k + e >= -3 && k + e <= 0;
      end
      default: return 1;
    endcase
  endfunction
  // stored word of one register as the bank exposes it
  function automatic logic [15:0] cfg_word(logic [7:0] c);
    case (c)
      8'h22: return cfg_out.trim;
      8'h24: return cfg_out.vmax;
      8'h25: return cfg_out.mhigh;
      8'h26: return cfg_out.mlow;
      8'h27: return cfg_out.slew;
      8'h29: return cfg_out.scale;
      8'h33: return cfg_out.fsw;
      8'h35: return cfg_out.input_turn_on_level;
      8'h36: return cfg_out.input_turn_off_level;
      8'h37: return cfg_out.phase;
      8'h40: return cfg_out.ovf;
      8'h41: return {8'h00, cfg_out.ovact};
      8'h42: return cfg_out.ovw;
      default: return cfg_out.uvw;
    endcase
  endfunction
  task automatic op(logic wr, logic [7:0] c, logic [15:0] d);
    bit ok;
    ok = mdl.exists(c) && (!wr || legal(c, d));
    rocb_host_inst.xfer(wr, c, d, rsp);
    check("ack", 16'(rsp.ack), 16'(ok));
    check("nack", 16'(rsp.nack), 16'(!ok));
    if (wr) check("bad_data", 16'(bad_data_out), 16'(!ok && mdl.exists(c)));
    if (!wr) check("rdata", rsp.rdata, ok ? mdl[c] : 16'h0000);
    if (wr && ok) mdl[c] = (c == 8'h37) ? (d & 16'h0ff0) : d;
    if (mdl.exists(c)) check("cfg", cfg_word(c), mdl[c]);
  endtask
  task automatic pins(logic [3:0] p, logic [1:0] e);
    @(posedge clk_in);
    #2 {ov_fault_in, cmd_on_in, bias_ok_in, other_fault_in} = p;
    repeat (6) @(posedge clk_in);
    check("enable", 16'(out_enable_out), 16'(e[1]));
    check("waiting", 16'(restart_wait_out), 16'(e[0]));
  endtask
  // hold reset n edges with a fresh factory trim, reload the model
  task automatic reset_dut(int n);
    rst_n_in = 0;
    factory_trim_in = 16'($urandom_range(2048)) - 16'h0400;
    mdl = '{'h22: factory_trim_in, 'h24: 16'h1c00, 'h25: 16'h0142,
      'h26: 16'h0123, 'h27: 16'he002, 'h29: 16'he808, 'h33: 16'h0258,
      'h35: 16'hf814, 'h36: 16'h0100, 'h37: 16'h0100, 'h40: 16'h0161,
      'h41: 16'h00f8, 'h42: 16'h0151, 'h43: 16'h0114};
    repeat (n) @(posedge clk_in);
    #2 rst_n_in = 1;
  endtask
  task automatic final_report;
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_in = 0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    void'($urandom(32'he462));
    {rst_n_in, ov_fault_in, cmd_on_in, bias_ok_in, other_fault_in} = 5'b00110;
    reset_dut(20);
    foreach (mdl[c]) op(0, 8'(c), 16'h0000);
    op(0, 8'h23, 16'h0000);
    op(1, 8'h28, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      op(1, fr[i % 4], 16'($urandom));
      op(0, fr[i % 4], 16'h0000);
    end
    foreach (wtab[i]) begin
      op(1, wtab[i][23:16], wtab[i][15:0]);
    end
    foreach (ptab[i]) begin
      op(1, 8'h37, ptab[i]);
      op(0, 8'h37, 16'h0000);
      repeat (2) @(posedge clk_in);
      check("master", 16'(phase_master_out),
            16'(ptab[i][7:4] == 4'h0));
      check("position", 16'(phase_pos_out), 16'(ptab[i][7:4]));
    end
    pins(4'b0110, 2'b10);
    pins(4'b1110, 2'b01);
    pins(4'b0110, 2'b10);
    pins(4'b1110, 2'b01);
    pins(4'b1010, 2'b00);
    pins(4'b0110, 2'b10);
    pins(4'b1110, 2'b01);
    pins(4'b1111, 2'b00);
    pins(4'b0110, 2'b10);
    pins(4'b1110, 2'b01);
    pins(4'b1100, 2'b00);
    pins(4'b0110, 2'b10);
    op(1, 8'h41, 16'h0000);
    pins(4'b1110, 2'b10);
    pins(4'b0110, 2'b10);
    op(1, 8'h41, 16'h00f8);
    foreach (mdl[c]) op(0, 8'(c), 16'h0000);
    #2 reset_dut(3);
    foreach (mdl[c]) op(0, 8'(c), 16'h0000);
    pins(4'b0110, 2'b10);
    final_report();
  end
endmodule
